// ==== core/tape_port_pkg.sv ====
// Shared constants and types for the tape drive transport port.
package tape_port_pkg;
	// System clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 10;
	// Bi-phase mark bit cell length in nanoseconds.
	localparam int CELL_NS = 70000;
	// Cycles in one bit cell (exact division).
	localparam int CELL_CYC = CELL_NS / CLK_PERIOD_NS;
	// Cycles in half a cell, used as the mid-cell mark.
	localparam int HALF_CYC = CELL_CYC / 2;
	// Cycles in three quarters of a cell, the decision point for recovery.
	localparam int TQ_CYC = (CELL_CYC * 3) / 4;
	// Cycles in a quarter cell, the least spacing of a real transition.
	localparam int Q_CYC = CELL_CYC / 4;
	// Cycles without any edge before the line is judged idle.
	localparam int IDLE_CYC = CELL_CYC * 2;
	// Tape speeds in inches per second.
	localparam int SLOW_IPS = 20;
	localparam int FAST_IPS = 80;
	// Cycles the transport needs to come up to speed after a run command.
	localparam int SPINUP_CYC = 1000;
	// Storage geometry: blocks per track and bytes per block.
	localparam int BLOCKS = 128;
	localparam int BLOCK_BYTES = 1024;
	// Counter width wide enough for every cycle count above.
	localparam int CNT_W = 14;
	// Reset value of the playback/record line (idle high).
	localparam logic LINE_IDLE = 1'b1;
	// Transport states of the drive end.
	typedef enum logic [1:0] {
		MOT_STOP,
		MOT_SPINUP,
		MOT_RUN
	} motion_t;
endpackage

// ==== core/tape_link_if.sv ====
// Pin bundle between the controller and the tape drive.
`timescale 1ns/1ns
interface tape_link_if;
	logic halt_clamp;	// Brake, active high.
	logic backward_run_n;	// Reverse run, active low.
	logic forward_run_n;	// Forward run, active low.
	logic motion_inhibit;	// Inhibit motion, active high.
	logic rate_select;	// 0 slow, 1 fast.
	logic motion_ok;	// Tape properly moving.
	logic pack_present_n;	// Cassette in place, active low.
	logic record_data;	// Bi-phase mark stream into the drive.
	logic head_side;	// 1 track A, 0 track B.
	logic record_mode_n;	// 0 write, 1 read.
	logic playback_data;	// Bi-phase mark stream out of the drive.
	// Drive end of the link.
	modport drive (
		input  halt_clamp, backward_run_n, forward_run_n, motion_inhibit, rate_select,
		input  record_data, head_side, record_mode_n,
		output motion_ok, pack_present_n, playback_data
	);
	// Controller end of the link.
	modport ctrl (
		output halt_clamp, backward_run_n, forward_run_n, motion_inhibit, rate_select,
		output record_data, head_side, record_mode_n,
		input  motion_ok, pack_present_n, playback_data
	);
endinterface

// ==== core/tape_drive_end.sv ====
// Drive end: transport state, status outputs and the record/playback path.
`timescale 1ns/1ns
module tape_drive_end (
	// Clock, reset and enable.
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// Link to the controller.
	tape_link_if.drive link,
	// Mechanism side.
	input  wire logic cassette_in,
	input  wire logic transport_fault,
	input  wire logic tape_play_bit,
	output logic      motor_fwd,
	output logic      motor_rev,
	output logic      brake_on,
	output logic      fast_speed,
	output logic      track_a,
	output logic      write_en,
	output logic      tape_write_bit
);
	// Two-stage synchronisers for every link input and mechanism pin, the head's playback bit included.
	localparam int NS = 11;
	// Reset levels equal the idle levels of the pins, so no false edge or glitch follows reset.
	localparam logic [NS-1:0] SYNC_IDLE = 11'h7b9;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1;
	logic [NS-1:0] s2;
	assign raw = {link.halt_clamp, link.backward_run_n, link.forward_run_n, link.motion_inhibit,
		link.rate_select, link.record_data, link.head_side, link.record_mode_n,
		cassette_in, transport_fault, tape_play_bit};

	// Each bit has its own pair of flops; the first is read only by the second.
	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1[g] <= SYNC_IDLE[g];
					s2[g] <= SYNC_IDLE[g];
				end else if (ce) begin
					s1[g] <= raw[g];
					s2[g] <= s1[g];
				end
			end
		end
	endgenerate

	// Named views of the synchronised inputs.
	logic halt, rev_n, fwd_n, inhibit, rate, rec_in, side, rmode_n, cass, fault, play;
	assign {halt, rev_n, fwd_n, inhibit, rate, rec_in, side, rmode_n, cass, fault, play} = s2;

	// Transport state and spin-up counter.
	tape_port_pkg::motion_t state, next_state;
	logic [tape_port_pkg::CNT_W-1:0] cnt, next_cnt;
	logic run_req;	// A single direction is commanded and nothing blocks motion.

	// Brake and inhibit stop motion; a conflicting run command is treated as stop.
	always_comb begin
		run_req = (fwd_n ^ rev_n) & ~halt & ~inhibit & cass & ~fault;
		next_state = state;
		next_cnt = cnt;
		case (state)
			tape_port_pkg::MOT_STOP: begin
				next_cnt = '0;
				if (run_req) begin
					next_state = tape_port_pkg::MOT_SPINUP;
				end
			end
			tape_port_pkg::MOT_SPINUP: begin
				// Motion is not reported until the transport has reached speed.
				if (!run_req) begin
					next_state = tape_port_pkg::MOT_STOP;
				end else if (cnt == tape_port_pkg::CNT_W'(tape_port_pkg::SPINUP_CYC - 1)) begin
					next_state = tape_port_pkg::MOT_RUN;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			tape_port_pkg::MOT_RUN: begin
				if (!run_req) begin
					next_state = tape_port_pkg::MOT_STOP;
				end
			end
			default: begin
				next_state = tape_port_pkg::MOT_STOP;
			end
		endcase
	end

	// Registers the transport state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= tape_port_pkg::MOT_STOP;
			cnt <= '0;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// Registered outputs toward the link and the mechanism.
	logic next_motion_ok, next_pack_n, next_play;
	logic next_mfwd, next_mrev, next_brake, next_fast, next_track, next_wen, next_wbit;
	always_comb begin
		next_motion_ok = (next_state == tape_port_pkg::MOT_RUN);
		next_pack_n = ~cass;
		// Playback passes the tape's bi-phase stream unchanged; inhibit forces it high while it is asserted.
		next_play = inhibit ? tape_port_pkg::LINE_IDLE : play;
		next_mfwd = run_req & ~fwd_n;
		next_mrev = run_req & ~rev_n;
		next_brake = halt;
		next_fast = rate;
		next_track = side;
		next_wen = ~rmode_n;
		// The record stream is written as-is; each level change is a flux change.
		next_wbit = rec_in;
	end

	// Registers all outputs.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.motion_ok <= 1'b0;
			link.pack_present_n <= 1'b1;
			link.playback_data <= tape_port_pkg::LINE_IDLE;
			motor_fwd <= 1'b0;
			motor_rev <= 1'b0;
			brake_on <= 1'b1;
			fast_speed <= 1'b0;
			track_a <= 1'b0;
			write_en <= 1'b0;
			tape_write_bit <= tape_port_pkg::LINE_IDLE;
		end else if (ce) begin
			link.motion_ok <= next_motion_ok;
			link.pack_present_n <= next_pack_n;
			link.playback_data <= next_play;
			motor_fwd <= next_mfwd;
			motor_rev <= next_mrev;
			brake_on <= next_brake;
			fast_speed <= next_fast;
			track_a <= next_track;
			write_en <= next_wen;
			tape_write_bit <= next_wbit;
		end
	end
endmodule

// ==== core/tape_ctrl_end.sv ====
// Controller end: motion commands, bi-phase mark encoder and decoder.
// Behaviour
// - Halt clamp high applies the brake.
// - Backward run low moves tape reverse.
// - Forward run low moves tape forward.
// - Inhibit high stops motion, playback high.
// - Inhibit low allows motion and playback.
// - Rate select: 0 is 20, 1 is 80 ips.
// - Motion status high only while properly moving.
// - Motion status low whenever tape is stopped.
// - Pack present low when cassette inserted.
// - Record cells last 70 microseconds each.
// - One is mid-cell transition, zero none.
// - Head side: 1 track A, 0 track B.
// - Record mode low writes, high reads.
// - Playback uses the same bi-phase format.
// - Controller recovers clock from line transitions.
// - Controller decodes stream back to binary.
// - Two tracks of 128 one-kilobyte blocks.
`timescale 1ns/1ns
module tape_ctrl_end (
	// Clock, reset and enable.
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Link to the drive.
	tape_link_if.ctrl       link,
	// Motion commands from the user.
	input  wire logic       cmd_fwd,
	input  wire logic       cmd_rev,
	input  wire logic       cmd_halt,
	input  wire logic       cmd_inhibit,
	input  wire logic       cmd_fast,
	input  wire logic       cmd_track_a,
	input  wire logic       cmd_write,
	// Block address, track bit above block number.
	input  wire logic [7:0] block_addr,
	output logic            addr_track_a,
	output logic [6:0]      addr_block,
	// Transmit bit stream.
	input  wire logic       tx_valid,
	input  wire logic       tx_bit,
	output logic            tx_ready,
	// Received bits and status.
	output logic            rx_valid,
	output logic            rx_bit,
	output logic            moving,
	output logic            pack_in
);
	// Two-stage synchronisers for the three inputs from the drive.
	// They reset to the idle levels so that the decoder sees no false edge after reset.
	localparam logic [2:0] SYNC_IDLE = 3'h6;
	logic [2:0] s1;
	logic [2:0] s2;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1[g] <= SYNC_IDLE[g];
					s2[g] <= SYNC_IDLE[g];
				end else if (ce) begin
					s1[g] <= (g == 0) ? link.motion_ok : (g == 1) ? link.pack_present_n : link.playback_data;
					s2[g] <= s1[g];
				end
			end
		end
	endgenerate

	// Command and address registers.
	logic next_fwd_n, next_rev_n, next_halt, next_inh, next_rate, next_side, next_rmode_n;
	always_comb begin
		// A halt or a double request drops both directions first.
		next_fwd_n = ~(cmd_fwd & ~cmd_rev & ~cmd_halt);
		next_rev_n = ~(cmd_rev & ~cmd_fwd & ~cmd_halt);
		// The brake is applied only once both run lines have been released.
		next_halt = cmd_halt & link.forward_run_n & link.backward_run_n;
		next_inh = cmd_inhibit;
		next_rate = cmd_fast;
		next_side = cmd_track_a;
		next_rmode_n = ~cmd_write;
	end

	// Registers the command lines and the decoded block address.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.forward_run_n <= 1'b1;
			link.backward_run_n <= 1'b1;
			link.halt_clamp <= 1'b1;
			link.motion_inhibit <= 1'b1;
			link.rate_select <= 1'b0;
			link.head_side <= 1'b1;
			link.record_mode_n <= 1'b1;
			addr_track_a <= 1'b1;
			addr_block <= 7'h00;
			moving <= 1'b0;
			pack_in <= 1'b0;
		end else if (ce) begin
			link.forward_run_n <= next_fwd_n;
			link.backward_run_n <= next_rev_n;
			link.halt_clamp <= next_halt;
			link.motion_inhibit <= next_inh;
			link.rate_select <= next_rate;
			link.head_side <= next_side;
			link.record_mode_n <= next_rmode_n;
			addr_track_a <= ~block_addr[7];
			addr_block <= block_addr[6:0];
			moving <= s2[0];
			pack_in <= ~s2[1];
		end
	end

	// Encoder: a level change at every cell start, another at mid-cell for a one.
	logic [tape_port_pkg::CNT_W-1:0] tcnt, next_tcnt;
	logic tbusy, next_tbusy, tbit, next_tbit, tline, next_tline;
	assign tx_ready = ~tbusy | (tcnt == tape_port_pkg::CNT_W'(tape_port_pkg::CELL_CYC - 1));
	always_comb begin
		next_tcnt = tcnt;
		next_tbusy = tbusy;
		next_tbit = tbit;
		next_tline = tline;
		if (tx_valid && tx_ready) begin
			next_tcnt = '0;
			next_tbusy = 1'b1;
			next_tbit = tx_bit;
			next_tline = ~tline;
		end else if (tbusy) begin
			if (tcnt == tape_port_pkg::CNT_W'(tape_port_pkg::CELL_CYC - 1)) begin
				next_tbusy = 1'b0;
			end else begin
				next_tcnt = tcnt + 1'b1;
				if (tcnt == tape_port_pkg::CNT_W'(tape_port_pkg::HALF_CYC - 1) && tbit) begin
					next_tline = ~tline;
				end
			end
		end
	end

	// Registers the encoder.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tcnt <= '0;
			tbusy <= 1'b0;
			tbit <= 1'b0;
			tline <= tape_port_pkg::LINE_IDLE;
		end else if (ce) begin
			tcnt <= next_tcnt;
			tbusy <= next_tbusy;
			tbit <= next_tbit;
			tline <= next_tline;
		end
	end
	assign link.record_data = tline;

	// Decoder: an edge opens a cell; an edge before three quarters marks a one.
	logic [tape_port_pkg::CNT_W-1:0] rcnt, next_rcnt;
	logic rprev, rmid, next_rmid, rlock, next_rlock, next_rxv, next_rxb;
	logic redge;
	assign redge = s2[2] ^ rprev;
	always_comb begin
		next_rcnt = (rcnt == tape_port_pkg::CNT_W'(tape_port_pkg::IDLE_CYC)) ? rcnt : rcnt + 1'b1;
		next_rmid = rmid;
		next_rlock = rlock;
		next_rxv = 1'b0;
		next_rxb = rx_bit;
		if (rcnt == tape_port_pkg::CNT_W'(tape_port_pkg::IDLE_CYC)) begin
			next_rlock = 1'b0;
		end
		if (redge && rcnt >= tape_port_pkg::CNT_W'(tape_port_pkg::Q_CYC)) begin
			if (rcnt < tape_port_pkg::CNT_W'(tape_port_pkg::TQ_CYC) && rlock && !rmid) begin
				next_rmid = 1'b1;
			end else begin
				// Cell boundary: the cell just closed is delivered.
				next_rxv = rlock;
				next_rxb = rmid;
				next_rmid = 1'b0;
				next_rlock = 1'b1;
				next_rcnt = '0;
			end
		end
	end

	// Registers the decoder.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rcnt <= '0;
			rprev <= tape_port_pkg::LINE_IDLE;
			rmid <= 1'b0;
			rlock <= 1'b0;
			rx_valid <= 1'b0;
			rx_bit <= 1'b0;
		end else if (ce) begin
			rcnt <= next_rcnt;
			rprev <= s2[2];
			rmid <= next_rmid;
			rlock <= next_rlock;
			rx_valid <= next_rxv;
			rx_bit <= next_rxb;
		end
	end
endmodule

// ==== verif/tape_link_properties.sv ====
// Concurrent checks on the wires between the two tape link ends.
`timescale 1ns/1ns
module tape_link_properties (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Link wires.
	input wire logic halt_clamp,
	input wire logic backward_run_n,
	input wire logic forward_run_n,
	input wire logic motion_inhibit,
	input wire logic motion_ok,
	input wire logic record_data,
	input wire logic playback_data
);
	logic [13:0] gap;	// Cycles since the record line last moved.
	logic        prev;	// Record line one cycle ago.
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// The gap starts full, so the first edge after reset is never judged.
	always_ff @(posedge clk) begin
		prev <= record_data;
		if (!rst_n) begin
			gap <= 14'h3fff;
		end else if (record_data != prev) begin
			gap <= 14'h0001;
		end else if (gap != 14'h3fff) begin
			gap <= gap + 14'h0001;
		end
	end
	a_run_exclusive: assert property (!(!forward_run_n && !backward_run_n))
		else $error("Both run lines are low.");
	a_halt_release: assert property ($rose(halt_clamp) |-> forward_run_n && backward_run_n)
		else $error("Brake applied while a run line is low.");
	a_motion_cause: assert property ($rose(motion_ok) |-> !halt_clamp && !motion_inhibit && forward_run_n != backward_run_n)
		else $error("Motion reported without a valid run command.");
	a_spinup_wait: assert property ($fell(forward_run_n) && !motion_ok |=> !motion_ok [*8])
		else $error("Motion reported too soon after a run command.");
	a_halt_stops: assert property (halt_clamp [*5] |-> !motion_ok)
		else $error("Motion reported while braking.");
	a_inhibit_stops: assert property (motion_inhibit [*5] |-> !motion_ok)
		else $error("Motion reported while inhibited.");
	a_inhibit_mutes: assert property (motion_inhibit [*5] |-> playback_data)
		else $error("Playback line not high while inhibited.");
	a_half_cell: assert property (record_data != prev |-> gap >= tape_port_pkg::HALF_CYC)
		else $error("Record line moved sooner than half a cell.");
endmodule

// ==== verif/tape_drive_transport_port_test.sv ====
// Self-checking bench joining the controller end to the drive end.
`timescale 1ns/1ns
module tape_drive_transport_port_test;
	logic clk, rst_n, cassette_in, transport_fault, cmd_fwd, cmd_rev, cmd_halt, cmd_inhibit;
	logic cmd_fast, cmd_track_a, cmd_write, tx_valid, tx_bit;
	logic [7:0] block_addr;
	logic motor_fwd, motor_rev, brake_on, fast_speed, track_a, write_en, tape_write_bit;
	logic addr_track_a, tx_ready, rx_valid, rx_bit, moving, pack_in;
	logic [6:0] addr_block;
	int err_total, n_checks;
	logic rxq[$];	// Bits decoded by the controller.
	logic [5:0] pat = 6'b101101;	// Stream sent, lowest bit first.
	tape_link_if link();
	// The head loops written flux straight back to playback.
	tape_drive_end i_tape_drive_end (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link), .cassette_in(cassette_in),
		.transport_fault(transport_fault), .tape_play_bit(tape_write_bit), .motor_fwd(motor_fwd),
		.motor_rev(motor_rev), .brake_on(brake_on), .fast_speed(fast_speed), .track_a(track_a),
		.write_en(write_en), .tape_write_bit(tape_write_bit));
	tape_ctrl_end i_tape_ctrl_end (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link), .cmd_fwd(cmd_fwd),
		.cmd_rev(cmd_rev), .cmd_halt(cmd_halt), .cmd_inhibit(cmd_inhibit), .cmd_fast(cmd_fast),
		.cmd_track_a(cmd_track_a), .cmd_write(cmd_write), .block_addr(block_addr),
		.addr_track_a(addr_track_a), .addr_block(addr_block), .tx_valid(tx_valid), .tx_bit(tx_bit),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit), .moving(moving), .pack_in(pack_in));
	tape_link_properties i_tape_link_properties (.clk(clk), .rst_n(rst_n), .halt_clamp(link.halt_clamp),
		.backward_run_n(link.backward_run_n), .forward_run_n(link.forward_run_n),
		.motion_inhibit(link.motion_inhibit), .motion_ok(link.motion_ok), .record_data(link.record_data),
		.playback_data(link.playback_data));
	// Clock of 10 ns.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Collect every decoded bit as it is pulsed out.
	always @(negedge clk) begin
		if (rx_valid === 1'b1) begin
			rxq.push_back(rx_bit);
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t %s: saw %h, expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Waits a bounded time for the motion status to reach a level.
	task automatic wait_motion(input logic v, input int lim);
		for (int k = 0; k < lim && link.motion_ok !== v; k++) tick(1);
		check(link.motion_ok, v, "motion status");
	endtask
	// Runs one way, then stops by brake (0), fault (1) or inhibit (2).
	task automatic run_and_stop(input logic fwd, input int cause);
		cmd_fwd = fwd;
		cmd_rev = !fwd;
		tick(900);
		check({link.forward_run_n, link.backward_run_n, motor_fwd, motor_rev, link.motion_ok},
			{!fwd, fwd, fwd, !fwd, 1'b0}, "run lines");
		wait_motion(1'b1, 300);
		tick(3);
		check(moving, 1'b1, "moving flag");
		cmd_halt = (cause == 0);
		cmd_fwd = (cause != 0) && fwd;
		cmd_rev = (cause != 0) && !fwd;
		transport_fault = (cause == 1);
		cmd_inhibit = (cause == 2);
		wait_motion(1'b0, 20);
		tick(5);
		if (cause == 0) check({link.halt_clamp, brake_on, link.forward_run_n, link.backward_run_n}, 4'hf, "brake");
		if (cause == 2) check(link.playback_data, 1'b1, "muted playback");
		{cmd_halt, cmd_fwd, cmd_rev, transport_fault, cmd_inhibit} = 5'h00;
		tick(5);
	endtask
	// Sends one bit and judges the line at a quarter and three quarters of its cell.
	task automatic send_bit(input logic b);
		logic lvl;
		tx_bit = b;
		tx_valid = 1'b1;
		for (int k = 0; k < 8000 && tx_ready !== 1'b1; k++) tick(1);
		lvl = link.record_data;
		tick(1);
		tx_valid = 1'b0;
		tick(tape_port_pkg::Q_CYC);
		check(link.record_data, !lvl, "cell start edge");
		tick(tape_port_pkg::HALF_CYC);
		check({tx_ready, link.record_data}, {1'b0, !(lvl ^ b)}, "mid cell");
	endtask
	initial begin
		{rst_n, cassette_in, transport_fault, cmd_fwd, cmd_rev, cmd_halt, cmd_inhibit} = 7'h00;
		{cmd_fast, cmd_track_a, cmd_write, tx_valid, tx_bit} = 5'h00;
		block_addr = 8'h00;
		tick(5);
		check({link.halt_clamp, link.forward_run_n, link.backward_run_n, link.motion_inhibit, link.record_data,
			link.motion_ok, link.pack_present_n, link.playback_data}, 8'hfb, "reset levels");
		rst_n = 1'b1;
		tick(1);
		cassette_in = 1'b1;
		tick(6);
		check({link.pack_present_n, pack_in}, 2'b01, "pack present");
		for (int i = 0; i < 4; i++) begin
			{cmd_track_a, cmd_fast} = i[1:0];
			cmd_write = i[0] ^ i[1];
			block_addr = {i[0], 7'h55 ^ i[6:0]};
			tick(6);
			check({link.rate_select, link.head_side, link.record_mode_n, fast_speed, track_a, write_en},
				{i[0], i[1], !cmd_write, i[0], i[1], cmd_write}, "modes");
			check({addr_track_a, addr_block}, {!i[0], 7'h55 ^ i[6:0]}, "address");
		end
		// A double run request must leave both run lines released.
		{cmd_fwd, cmd_rev} = 2'h3;
		tick(4);
		check({link.forward_run_n, link.backward_run_n, motor_fwd, motor_rev}, 4'hc, "double run");
		{cmd_fwd, cmd_rev} = 2'h0;
		tick(2);
		run_and_stop(1'b1, 0);
		run_and_stop(1'b0, 1);
		run_and_stop(1'b1, 2);
		cmd_write = 1'b1;
		tick(20);
		for (int i = 0; i < 6; i++) send_bit(pat[i]);
		tick(tape_port_pkg::CELL_CYC);
		// The first edge only locks; the last cell waits for a following edge.
		check(rxq.size(), 5, "decoded count");
		for (int i = 0; i < 5 && i < rxq.size(); i++) check(rxq[i], pat[i], "decoded bit");
		// With the record line held low, inhibit must still force playback high.
		send_bit(1'b0);
		cmd_inhibit = 1'b1;
		tick(8);
		check({link.record_data, link.playback_data}, 2'h1, "muted low line");
		cmd_inhibit = 1'b0;
		report_and_stop();
	end
	// Watchdog well beyond the roughly 60000 cycles that the tests take.
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
endmodule
